// ===== lic_params.svh
// Register offsets, field positions and reset values of the indicator block.
`ifndef LIC_PARAMS_SVH
`define LIC_PARAMS_SVH
`define LIC_ADDR_LAMP_WORD   12'h000
`define LIC_ADDR_USER_LAMPS  12'h004
`define LIC_ADDR_BOARD_STAT  12'h008
`define LIC_LAMP_WORD_RESET  4'hf
`define LIC_USER_LAMPS_RESET 4'hf
`define LIC_STAT_CFG_BIT     4
`define LIC_STAT_USB_BIT     5
`define LIC_SYNC_STAGES      2
`endif

// ===== lic_pkg.sv
// Types shared by the indicator block.
package lic_pkg;
  // Colour shown by one tricolour lamp.
  typedef enum logic [1:0]
  {
    lic_dark_type_v   = 2'h0,
    lic_red_type_v    = 2'h1,
    lic_green_type_v  = 2'h2,
    lic_yellow_type_v = 2'h3
  } lic_colour_type;
endpackage

// ===== lic_sync.sv
// Two-stage synchroniser for a bundle of board level inputs.
module lic_sync
  import lic_pkg::*;
#(
  parameter int WIDTH = 6
)
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  // First stage; only the second stage reads it.
  logic [WIDTH-1:0] meta;

  // Both stages clear to zero so supplies read as off until sampled.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      meta     <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ===== lic_lamp.sv
// Colour to active-low cathode drive for one tricolour lamp.
module lic_lamp
  import lic_pkg::*;
(
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire lic_colour_type colour,
  output logic                red_n,
  output logic                green_n
);
  // Registered so cathode pins come from flip-flops; dark out of reset.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      red_n   <= 1'b1;
      green_n <= 1'b1;
    end
    else
    begin
      // Red element lit for red or yellow, zero means lit.
      red_n   <= ~colour[0];
      green_n <= ~colour[1];
    end
  end
endmodule

// ===== lic_top.sv
// Indicator lamp controller with APB access to the status lamp word.
//
// Chosen here: the APB interface to the registers and the address map.
`include "lic_params.svh"

module lic_top
  import lic_pkg::*;
#(
  parameter int LAMPS = 4
)
(
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             supply_a,
  input  wire logic             supply_b,
  input  wire logic             supply_c,
  input  wire logic             supply_d,
  input  wire logic             config_done,
  input  wire logic             usb_started,
  input  wire logic             user_lamp1_red,
  input  wire logic             user_lamp1_green,
  input  wire logic             user_lamp2_red,
  input  wire logic             user_lamp2_green,
  output logic      [LAMPS-1:0] status_lamp_n,
  output logic      [3:0]       supply_red_n,
  output logic      [3:0]       supply_green_n,
  output logic                  config_lamp_n,
  output logic                  usb_lamp_green_n,
  output logic                  user_lamp1_red_n,
  output logic                  user_lamp1_green_n,
  output logic                  user_lamp2_red_n,
  output logic                  user_lamp2_green_n
);
  // Host written lamp word; a zero bit lights its lamp.
  logic [LAMPS-1:0] lamp_word;
  // Synchronised board levels: supplies a..d, done, usb.
  logic [5:0]       board_sync;
  // Registered user lamp requests, active high.
  logic [3:0]       user_req;
  // Access phase strobes.
  logic             apb_access;
  logic             apb_write;
  logic             apb_read;
  logic             addr_ok;

  // Decodes whether an address hits a mapped register.
  function automatic logic lic_mapped(input logic [11:0] a);
    lic_mapped = (a == `LIC_ADDR_LAMP_WORD) ||
                 (a == `LIC_ADDR_USER_LAMPS) ||
                 (a == `LIC_ADDR_BOARD_STAT);
  endfunction

  // Zero wait states keep software read-modify-write cheap.
  assign apb_access = psel && penable;
  assign apb_write  = apb_access && pwrite;
  assign apb_read   = apb_access && !pwrite;
  assign addr_ok    = lic_mapped(paddr);
  assign pready     = 1'b1;
  assign pslverr    = apb_access && !addr_ok;

  // Board levels come from other domains and are synchronised first.
  lic_sync #(
    .WIDTH (6)
  ) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({usb_started, config_done,
                supply_d, supply_c, supply_b, supply_a}),
    .sync_out (board_sync)
  );

  // Lamp word register; only the host writes it, reset darkens lamps 0 to 3 and lights any lamp above 3.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      lamp_word <= LAMPS'(`LIC_LAMP_WORD_RESET);
    end
    else if (apb_write && paddr == `LIC_ADDR_LAMP_WORD)
    begin
      lamp_word <= pwdata[LAMPS-1:0];
    end
  end

  // Status lamp pins follow the word bit for bit, zero lit.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      status_lamp_n <= '1;
    end
    else
    begin
      status_lamp_n <= lamp_word;
    end
  end

  // Read data mux; unmapped reads answer zero with an error.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      prdata <= '0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata <= '0;
      if (paddr == `LIC_ADDR_LAMP_WORD)
      begin
        prdata[LAMPS-1:0] <= lamp_word;
      end
      else if (paddr == `LIC_ADDR_USER_LAMPS)
      begin
        prdata[3:0] <= user_req;
      end
      else if (paddr == `LIC_ADDR_BOARD_STAT)
      begin
        prdata[5:0] <= board_sync;
      end
    end
  end

  // User requests are registered from same-domain user logic.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      user_req <= '0;
    end
    else
    begin
      user_req <= {user_lamp2_green, user_lamp2_red,
                   user_lamp1_green, user_lamp1_red};
    end
  end

  // Two user lamps, each with its own red and green line.
  lic_lamp u_user1 (
    .mclk    (mclk),
    .reset   (reset),
    .colour  (lic_colour_type'(user_req[1:0])),
    .red_n   (user_lamp1_red_n),
    .green_n (user_lamp1_green_n)
  );
  lic_lamp u_user2 (
    .mclk    (mclk),
    .reset   (reset),
    .colour  (lic_colour_type'(user_req[3:2])),
    .red_n   (user_lamp2_red_n),
    .green_n (user_lamp2_green_n)
  );

  // Supply lamps: red when power is not good, green when it is.
  // Reset shows red, matching an unpowered card at power up.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_supply
      lic_lamp u_supply (
        .mclk    (mclk),
        .reset   (1'b0),
        .colour  ((reset || !board_sync[gi]) ? lic_red_type_v
                                             : lic_green_type_v),
        .red_n   (supply_red_n[gi]),
        .green_n (supply_green_n[gi])
      );
    end
  endgenerate

  // Configuration and USB lamps follow their start-up signals.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      config_lamp_n    <= 1'b1;
      usb_lamp_green_n <= 1'b1;
    end
    else
    begin
      config_lamp_n    <= ~board_sync[`LIC_STAT_CFG_BIT];
      usb_lamp_green_n <= ~board_sync[`LIC_STAT_USB_BIT];
    end
  end

  // Checks on the lamp behaviour.
  property p_word_drive;
    @(posedge mclk) disable iff (reset)
    (apb_write && paddr == `LIC_ADDR_LAMP_WORD)
      |=> ##1 status_lamp_n == $past(pwdata[LAMPS-1:0], 2);
  endproperty
  a_word_drive: assert property (p_word_drive)
    else $error("status lamps do not follow written word");

  property p_word_bit0;
    @(posedge mclk) disable iff (reset)
    ##1 status_lamp_n[0] == $past(lamp_word[0]);
  endproperty
  a_word_bit0: assert property (p_word_bit0)
    else $error("status lamp zero not on bit zero");

  property p_readback;
    @(posedge mclk) disable iff (reset)
    (apb_read && paddr == `LIC_ADDR_LAMP_WORD && $past(psel && !penable))
      |-> prdata[LAMPS-1:0] == $past(lamp_word);
  endproperty
  a_readback: assert property (p_readback)
    else $error("lamp word read back wrong");

  property p_word_hold;
    @(posedge mclk) disable iff (reset)
    !(apb_write && paddr == `LIC_ADDR_LAMP_WORD) |=> $stable(lamp_word);
  endproperty
  a_word_hold: assert property (p_word_hold)
    else $error("lamp word changed without host write");

  property p_supply_colour;
    @(posedge mclk) disable iff (reset)
    ##1 (supply_red_n[0] == $past(board_sync[0])) &&
        (supply_green_n[0] == !$past(board_sync[0]));
  endproperty
  a_supply_colour: assert property (p_supply_colour)
    else $error("supply lamp colour wrong");

  property p_supply_off;
    @(posedge mclk) disable iff (reset)
    $past(board_sync[1]) == 1'b0 |-> !supply_red_n[1] && supply_green_n[1];
  endproperty
  a_supply_off: assert property (p_supply_off)
    else $error("unpowered supply not red");

  property p_config;
    @(posedge mclk) disable iff (reset)
    !config_lamp_n |-> $past(board_sync[`LIC_STAT_CFG_BIT]);
  endproperty
  a_config: assert property (p_config)
    else $error("configuration lamp lit before done");

  property p_usb;
    @(posedge mclk) disable iff (reset)
    board_sync[`LIC_STAT_USB_BIT] [*2] |-> !usb_lamp_green_n;
  endproperty
  a_usb: assert property (p_usb)
    else $error("usb lamp not green");

  property p_yellow;
    @(posedge mclk) disable iff (reset)
    (user_req[1:0] == 2'h3) |=> !user_lamp1_red_n && !user_lamp1_green_n;
  endproperty
  a_yellow: assert property (p_yellow)
    else $error("user lamp not yellow");

  property p_user_reset;
    @(posedge mclk)
    reset |=> user_lamp1_red_n && user_lamp1_green_n &&
              user_lamp2_red_n && user_lamp2_green_n;
  endproperty
  a_user_reset: assert property (p_user_reset)
    else $error("user lamp lit after reset");

  // Lamp two asked for green alone must light only its green diode.
  property p_user2_green;
    @(posedge mclk) disable iff (reset)
    (user_req[3:2] == 2'h2) |=> user_lamp2_red_n && !user_lamp2_green_n;
  endproperty
  a_user2_green: assert property (p_user2_green)
    else $error("user lamp two not green");

  // A single low cathode shows its own colour only.
  property p_user2_red;
    @(posedge mclk) disable iff (reset)
    (user_req[3:2] == 2'h1) |=> !user_lamp2_red_n && user_lamp2_green_n;
  endproperty
  a_user2_red: assert property (p_user2_red)
    else $error("user lamp two not red");

  // With no request both cathodes stay high and the lamp is dark.
  property p_user1_dark;
    @(posedge mclk) disable iff (reset)
    (user_req[1:0] == 2'h0) |=> user_lamp1_red_n && user_lamp1_green_n;
  endproperty
  a_user1_dark: assert property (p_user1_dark)
    else $error("user lamp one lit without request");

  // The user request word reads back as it stood at the setup edge.
  property p_user_readback;
    @(posedge mclk) disable iff (reset)
    (apb_read && paddr == `LIC_ADDR_USER_LAMPS && $past(psel && !penable))
      |-> prdata[3:0] == $past(user_req);
  endproperty
  a_user_readback: assert property (p_user_readback)
    else $error("user request read back wrong");

  c_word_write: cover property (@(posedge mclk) disable iff (reset)
    apb_write && paddr == `LIC_ADDR_LAMP_WORD && pwdata[3:0] == 4'h9);
  c_word_read: cover property (@(posedge mclk) disable iff (reset)
    apb_read && paddr == `LIC_ADDR_LAMP_WORD);
  c_supply_up: cover property (@(posedge mclk) disable iff (reset)
    $rose(board_sync[0]));
  c_unmapped: cover property (@(posedge mclk) disable iff (reset)
    pslverr);
endmodule

// ===== lic_lamp_model.sv
// Behavioural model of one tricolour indicator lamp and its two cathodes.
module lic_lamp_model
  import lic_pkg::*;
(
  input  wire logic      red_n,
  input  wire logic      green_n,
  output lic_colour_type colour
);
  timeunit 1ns;
  timeprecision 1ns;
  // A low cathode lights its diode, and both low together mix to yellow.
  // The colour is decoded straight from the pins, so a floating cathode
  // shows up as an unknown colour instead of passing for dark.
  assign colour = lic_colour_type'({~green_n, ~red_n});
endmodule

// ===== lic_top_bench.sv
// Self-checking testbench of the indicator lamp controller.
module lic_top_bench
  import lic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic           mclk, reset, psel, penable, pwrite;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, rd, wr_word;
  logic           pready, pslverr, err;
  logic [3:0]     sup, usr, st_n, red_n, grn_n;
  logic           cfg, usb, cfg_n, usb_n, u1r_n, u1g_n, u2r_n, u2g_n;
  lic_colour_type lamp1, lamp2;
  int             num_errors, num_checks;
  // The design under test, with every input driven by the bench.
  lic_top lic_top_inst (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_a(sup[0]), .supply_b(sup[1]), .supply_c(sup[2]),
    .supply_d(sup[3]), .config_done(cfg), .usb_started(usb),
    .user_lamp1_red(usr[0]), .user_lamp1_green(usr[1]),
    .user_lamp2_red(usr[2]), .user_lamp2_green(usr[3]),
    .status_lamp_n(st_n), .supply_red_n(red_n), .supply_green_n(grn_n),
    .config_lamp_n(cfg_n), .usb_lamp_green_n(usb_n),
    .user_lamp1_red_n(u1r_n), .user_lamp1_green_n(u1g_n),
    .user_lamp2_red_n(u2r_n), .user_lamp2_green_n(u2g_n));
  // User lamps one and two seen through the cathode model.
  lic_lamp_model lic_lamp_model_inst (.red_n(u1r_n), .green_n(u1g_n),
    .colour(lamp1));
  lic_lamp_model lic_lamp_model_inst2 (.red_n(u2r_n), .green_n(u2g_n),
    .colour(lamp2));
  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 mclk = ~mclk;
  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Lets a number of rising edges pass.
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One APB transfer; entered just after a rising edge, ends after one.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    // Wait for the slave under a bounded count of edges.
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      num_errors++;
      end_of_test();
    end
    else
    begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // A spare edge keeps the next setup out of this time step.
      @(posedge mclk);
    end
  endtask
  // Main sequence of tests.
  initial
  begin
    mclk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {sup, cfg, usb, usr} = '0;
    num_errors = 0;
    num_checks = 0;
    tick(4);
    reset <= 1'b0;
    tick(1);
    // Out of reset every lamp is dark and each supply lamp shows red.
    check({28'h0, st_n}, 32'hf);
    check({24'h0, grn_n, red_n}, 32'hf0);
    check({28'h0, u2g_n, u2r_n, u1g_n, u1r_n}, 32'hf);
    check({30'h0, cfg_n, usb_n}, 32'h3);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'hf);
    $display("reset test done");
    // A zero in the word lights its lamp, bit i on status lamp i.
    for (int i = 0; i < 5; i++)
    begin
      wr_word = (i == 4) ? 32'h9 : (32'hf & ~(32'h1 << i));
      apb(1'b1, 12'h000, wr_word);
      tick(2);
      check({28'h0, st_n}, wr_word);
      apb(1'b0, 12'h000, 32'h0);
      check(rd, wr_word);
      check({31'h0, err}, 32'h0);
    end
    // Only four bits are kept: upper write bits read back as zero.
    apb(1'b1, 12'h000, 32'hffff_fff0);
    tick(2);
    check({28'h0, st_n}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    // An unmapped place reads zero, answers with an error, stores nothing.
    apb(1'b1, 12'h00c, 32'h5);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    check(rd, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    $display("lamp word test done");
    // Supply lamps follow power good: red when bad, green when good.
    for (int p = 5; p < 11; p += 5)
    begin
      sup <= p[3:0];
      tick(4);
      check({24'h0, grn_n, red_n}, {24'h0, ~p[3:0], p[3:0]});
    end
    // Configuration and the USB chip light their lamps once started.
    {cfg, usb} <= 2'h3;
    tick(4);
    check({30'h0, cfg_n, usb_n}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h3a);
    $display("board lamp test done");
    // User lamps: lamp one both diodes for yellow, lamp two green only.
    usr <= 4'hb;
    tick(3);
    check({30'h0, lamp1}, {30'h0, lic_yellow_type_v});
    check({30'h0, lamp2}, {30'h0, lic_green_type_v});
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'hb);
    usr <= 4'h4;
    tick(3);
    check({28'h0, lamp2, lamp1}, {28'h0, lic_red_type_v, lic_dark_type_v});
    $display("user lamp test done");
    // A reset in mid-run darkens every lamp and turns supplies red.
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(1);
    check({28'h0, u2g_n, u2r_n, u1g_n, u1r_n}, 32'hf);
    check({24'h0, grn_n, red_n}, 32'hf0);
    check({28'h0, st_n}, 32'hf);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'hf);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
